// ### design/lvdc_pkg.sv
// lvdc_pkg: constants for the low-voltage detect control block.
// assumes a 100 MHz bus clock and byte-wide cpu register accesses.
package lvdc_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [15:0] LVDC_ADDR_CTRL   = 16'hFFBE;
   localparam logic [15:0] LVDC_ADDR_LEVEL  = 16'hFFBF;
   localparam logic [7:0]  LVDC_CTRL_RESET  = 8'h00;
   localparam logic [3:0]  LVDC_LEVEL_RESET = 4'h0;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int LVDC_BIT_ENABLE = 7;
   localparam int LVDC_BIT_MODE   = 1;
   localparam int LVDC_BIT_FLAG   = 0;
   localparam int LVDC_LEVEL_W    = 4;

   // level code of the 2.70 V threshold used by the power-up default start
   localparam logic [3:0] LVDC_DEFAULT_LEVEL = 4'hA;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int LVDC_CLK_NS    = 10;
   localparam int LVDC_STAB_NS   = 10000;
   localparam int LVDC_FILT_US   = 200;
   // least times, rounded up to whole cycles
   localparam int LVDC_STAB_CYC  = (LVDC_STAB_NS + LVDC_CLK_NS - 1) / LVDC_CLK_NS;
   localparam int LVDC_FILT_CYC  = (LVDC_FILT_US * 1000 + LVDC_CLK_NS - 1) / LVDC_CLK_NS;
   localparam int LVDC_STAB_W    = $clog2(LVDC_STAB_CYC + 1);

   // ************************************************************
   // sequencer states
   // ************************************************************
   typedef enum logic [2:0] {
      LVDC_IDLE   = 3'b001,
      LVDC_SETTLE = 3'b010,
      LVDC_RUN    = 3'b100
   } lvdc_state_t;

endpackage

// ### design/lvdc_top.sv
// lvdc_top: enable/mode/flag and level-select registers of the supply
// low-voltage detector, comparator control, reset and interrupt requests.
// assumes an analogue comparator outside and a reset controller that
// pulses sys_rst_i for every reset other than the one requested here.
`timescale 1ns/100ps

// Behaviour
// RQ1: mode 0 raises an interrupt on both falling-below and returning-above crossings.
// RQ2: mode 1 holds the internal reset while below the level, releases above.
// RQ3: flag reads 1 only while below; 0 when above or disabled.
// RQ4: control register clears on other resets, survives detector resets.
// RQ5: enable at bit 7, mode at bit 1, read-only flag bit 0, rest zero.
// RQ6: enable starts comparator; result ignored for 10 us stabilisation.
// RQ7: supply must stay below 200 us before the flag sets.
// RQ8: low four bits of level register pick one of sixteen thresholds.
// RQ9: level register clears on other resets, survives detector resets.
// RQ10: software writes zero to level register upper bits.
// RQ11: software leaves the level alone while detection is enabled.
// RQ12: reset mode start order: mask, level, enable, wait, poll, mode.
// RQ13: stop by writing zero, or clear mode then enable.
// RQ14: disabling in interrupt mode while below raises an interrupt.
// RQ15: interrupt mode start order: mask, level, mode, enable, wait, unmask.
// RQ16: any reset forces the detector interrupt mask set.
// RQ17: a detector reset records itself in the reset cause register.
// RQ18: service routine checks flag and clears the request flag.
// RQ19: software waits out supply fluctuation after reset release.
// RQ20: default start option runs reset mode at 2.70 V from power-up.
// RQ21: enable 1 activates detection, 0 stops reset and interrupt.
// RQ22: comparator output passes a two-stage synchroniser first.
// RQ23: each detection change in interrupt mode gives one-cycle interrupt pulse.
module lvdc_top
   import lvdc_pkg::*;
#(
   parameter int FILT_CYCLES = LVDC_FILT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [15:0] bus_addr_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   input  wire logic [7:0]  bus_wdata_i,
   output logic      [7:0]  bus_rdata_o,
   input  wire logic        default_start_option_i,
   input  wire logic        cmp_below_i,
   output logic             cmp_en_o,
   output logic      [3:0]  cmp_level_o,
   output logic             detect_irq_o,
   output logic             detect_reset_o,
   output logic             detect_reset_cause_set_o,
   output logic             detect_irq_mask_set_o
);

   localparam int FILT_W = $clog2(FILT_CYCLES + 1);

   // every check in this module runs on the bus clock and sleeps through sys_rst_i
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // ************************************************************
   // register file
   // ************************************************************
   logic              detect_enable;
   logic              detect_mode_select;
   logic [3:0]        level_code;
   logic              strap_taken;
   logic              default_active;
   wire               wr_ctrl  = bus_wr_i & (bus_addr_i == LVDC_ADDR_CTRL);
   wire               wr_level = bus_wr_i & (bus_addr_i == LVDC_ADDR_LEVEL);
   wire               rd_ctrl  = bus_rd_i & (bus_addr_i == LVDC_ADDR_CTRL);
   wire               rd_level = bus_rd_i & (bus_addr_i == LVDC_ADDR_LEVEL);

   // only sys_rst_i clears these; the detector's own reset never reaches here
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         detect_enable      <= LVDC_CTRL_RESET[LVDC_BIT_ENABLE]; // RQ4
         detect_mode_select <= LVDC_CTRL_RESET[LVDC_BIT_MODE];
         level_code         <= LVDC_LEVEL_RESET;                 // RQ9
      end else begin
         if (wr_ctrl) begin
            detect_enable      <= bus_wdata_i[LVDC_BIT_ENABLE];  // RQ5
            detect_mode_select <= bus_wdata_i[LVDC_BIT_MODE];
         end
         if (wr_level) begin
            level_code <= bus_wdata_i[LVDC_LEVEL_W-1:0];         // RQ8
         end
      end
   end

   // strap is caught on the first clock after release, never by the reset itself
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         strap_taken    <= 1'b0;
         default_active <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken    <= 1'b1;
         default_active <= default_start_option_i;              // RQ20
      end else if (wr_ctrl) begin
         default_active <= 1'b0;
      end
   end

   // default start overrides the registers, whose enable, mode and level bits keep reading 0
   wire       en_eff    = detect_enable | default_active;       // RQ21
   wire       mode_eff  = detect_mode_select | default_active;  // RQ20
   wire [3:0] level_eff = default_active ? LVDC_DEFAULT_LEVEL : level_code;

   // ************************************************************
   // comparator synchroniser and filter
   // ************************************************************
   logic              below_meta;
   logic              below_s;
   logic [FILT_W-1:0] filt_cnt;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         below_meta <= 1'b0;
         below_s    <= 1'b0;
      end else begin
         below_meta <= cmp_below_i;                             // RQ22
         below_s    <= below_meta;
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   lvdc_state_t            state;
   lvdc_state_t            next_state;
   logic [LVDC_STAB_W-1:0] stab_cnt;
   logic                   det;

   wire stab_done   = (stab_cnt == LVDC_STAB_W'(LVDC_STAB_CYC - 1));
   wire below_filt  = (filt_cnt == FILT_W'(FILT_CYCLES));
   wire next_det    = (state == LVDC_RUN) & en_eff & below_filt;  // RQ3
   wire next_rst    = en_eff & mode_eff & next_det;               // RQ2
   wire next_irq    = ~mode_eff & (next_det ^ det);               // RQ1 RQ14 RQ23

   always_comb begin
      next_state = state;
      case (state)
         LVDC_IDLE:   if (en_eff) next_state = LVDC_SETTLE;       // RQ6
         LVDC_SETTLE: begin
            if (!en_eff) next_state = LVDC_IDLE;
            else if (stab_done) next_state = LVDC_RUN;
         end
         LVDC_RUN:    if (!en_eff) next_state = LVDC_IDLE;
         default:     next_state = LVDC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state    <= LVDC_IDLE;
         stab_cnt <= '0;
      end else begin
         state    <= next_state;
         stab_cnt <= (state == LVDC_SETTLE) ? stab_cnt + 1'b1 : '0;
      end
   end

   // low supply must persist through the whole window; any high sample restarts it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         filt_cnt <= '0;
      end else if (state != LVDC_RUN || !below_s) begin
         filt_cnt <= '0;
      end else if (!below_filt) begin
         filt_cnt <= filt_cnt + 1'b1;                            // RQ7
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         det                      <= 1'b0;
         detect_irq_o             <= 1'b0;
         detect_reset_o           <= 1'b0;
         detect_reset_cause_set_o <= 1'b0;
         detect_irq_mask_set_o    <= 1'b1;                       // RQ16
         cmp_en_o                 <= 1'b0;
         cmp_level_o              <= LVDC_LEVEL_RESET;
      end else begin
         det                      <= next_det;
         detect_irq_o             <= next_irq;
         detect_reset_o           <= next_rst;
         detect_reset_cause_set_o <= next_rst & ~detect_reset_o; // RQ17
         detect_irq_mask_set_o    <= next_rst;                   // RQ16
         cmp_en_o                 <= en_eff;                     // RQ6
         cmp_level_o              <= level_eff;
      end
   end

   // unmapped addresses read zero; data appears the cycle after the strobe
   wire [7:0] ctrl_view  = {detect_enable, 5'b0_0000, detect_mode_select, det}; // RQ5
   wire [7:0] level_view = {4'h0, level_code};
   wire [7:0] next_rdata = rd_ctrl ? ctrl_view : (rd_level ? level_view : 8'h00);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_rdata_o <= 8'h00;
      end else begin
         bus_rdata_o <= next_rdata;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   a_irq_on_change: assert property ( // RQ1
      ($changed(det) && !$past(mode_eff)) |-> detect_irq_o)
      else $error("no interrupt pulse on detection change");
   a_irq_one_cycle: assert property ( // RQ23
      detect_irq_o |-> $changed(det) && !$past(mode_eff))
      else $error("interrupt without detection change");
   a_reset_follows_det: assert property ( // RQ2
      detect_reset_o == ($past(en_eff && mode_eff) && det))
      else $error("internal reset does not track detection");
   a_flag_readback: assert property ( // RQ3
      rd_ctrl |=> bus_rdata_o[LVDC_BIT_FLAG] == $past(det))
      else $error("flag read differs from detection state");
   a_ctrl_zero_bits: assert property ( // RQ5
      rd_ctrl |=> bus_rdata_o[6:2] == 5'b0_0000)
      else $error("reserved control bits not zero");
   a_settle_blank: assert property ( // RQ6
      $rose(cmp_en_o) |-> ##1 !det [*8])
      else $error("detection during stabilisation");
   a_filter_window: assert property ( // RQ7
      $rose(det) |-> $past(filt_cnt) == FILT_W'(FILT_CYCLES))
      else $error("detection before filter window elapsed");
   a_level_write: assert property ( // RQ8
      wr_level |=> level_code == $past(bus_wdata_i[3:0]))
      else $error("level code not stored");
   a_disable_irq: assert property ( // RQ14
      ($fell(en_eff) && !mode_eff && det) |=> detect_irq_o)
      else $error("no interrupt when disabling below level");
   a_mask_forced: assert property ( // RQ16
      detect_reset_o |-> detect_irq_mask_set_o)
      else $error("mask not forced during detector reset");
   a_cause_pulse: assert property ( // RQ17
      $rose(detect_reset_o) |-> detect_reset_cause_set_o ##1 !detect_reset_cause_set_o)
      else $error("reset cause not pulsed once");
   a_default_start: assert property ( // RQ20
      default_active |-> (level_eff == LVDC_DEFAULT_LEVEL) && mode_eff && en_eff)
      else $error("default start not in reset mode at 2.70 V");

   // register contents change only by a write of their own address
   a_ctrl_write: assert property ( // RQ5
      wr_ctrl |=> detect_enable == $past(bus_wdata_i[LVDC_BIT_ENABLE])
                  && detect_mode_select == $past(bus_wdata_i[LVDC_BIT_MODE]))
      else $error("control write not stored");
   a_ctrl_hold: assert property ( // RQ4
      !wr_ctrl |=> $stable(detect_enable) && $stable(detect_mode_select))
      else $error("control bits changed without a write");
   a_level_hold: assert property ( // RQ9
      !wr_level |=> $stable(level_code))
      else $error("level code changed without a write");
   a_level_readback: assert property ( // RQ8
      rd_level |=> bus_rdata_o == {4'h0, $past(level_code)})
      else $error("level read differs from stored code");

   // detection and the reset request stay silent unless enabled; each request only in its own mode
   a_flag_disabled: assert property ( // RQ3
      !en_eff |=> !det)
      else $error("flag set while detection disabled");
   a_stop_quiet: assert property ( // RQ21
      !$past(en_eff) |-> !detect_reset_o && !det)
      else $error("reset or flag while detection stopped");
   a_irq_mode_only: assert property ( // RQ2
      $past(mode_eff) |-> !detect_irq_o)
      else $error("interrupt raised in reset mode");
   a_reset_mode_only: assert property ( // RQ1
      !$past(mode_eff) |-> !detect_reset_o)
      else $error("internal reset raised in interrupt mode");
   a_cause_on_rise: assert property ( // RQ17
      detect_reset_cause_set_o |-> $rose(detect_reset_o))
      else $error("reset cause pulse without a new reset");
   a_mask_release: assert property ( // RQ16
      !next_rst |=> !detect_irq_mask_set_o)
      else $error("mask forced with no detector reset");
   a_det_in_run: assert property ( // RQ6
      det |-> $past(state == LVDC_RUN))
      else $error("detection outside the running state");

   // the comparator sees the effective settings one cycle later, and its
   // answer reaches the filter only through both synchroniser stages
   a_cmp_enable: assert property ( // RQ6
      cmp_en_o == $past(en_eff))
      else $error("comparator enable does not follow the enable bit");
   a_level_drive: assert property ( // RQ8
      cmp_level_o == $past(level_eff))
      else $error("comparator level does not follow the level code");
   a_sync_chain: assert property ( // RQ22
      below_s == $past(below_meta))
      else $error("synchroniser stage skipped");

   c_irq_seen:     cover property (detect_irq_o);
   c_below_seen:   cover property ($rose(det));
   c_reset_seen:   cover property ($rose(detect_reset_o));
   c_disable_irq:  cover property ($fell(en_eff) && det);
   c_default_run:  cover property (default_active && state == LVDC_RUN);

endmodule

// ### tb/lvdc_cmp_model.sv
// lvdc_cmp_model: behavioural supply comparator on the far side of lvdc_top.
// assumes the bench sets the supply in millivolts and the bus clock runs free.
`timescale 1ns/100ps
module lvdc_cmp_model (
   input  wire logic        clk_i,
   input  wire logic        cmp_en_i,
   input  wire logic [3:0]  cmp_level_i,
   input  wire logic [15:0] supply_mv_i,
   output logic             cmp_below_o
);
   // code 0 is the highest threshold, rising codes step down
   logic [15:0] thr_mv [16] = '{16'h1090, 16'h0FFA, 16'h0F5A, 16'h0EC4, 16'h0E24, 16'h0D8E,
      16'h0CF8, 16'h0C58, 16'h0BC2, 16'h0B22, 16'h0A8C, 16'h09F6, 16'h0956, 16'h08C0,
      16'h0820, 16'h078A};
   initial cmp_below_o = 1'b0;
   always @(posedge clk_i) begin
      if (cmp_en_i) begin
         cmp_below_o <= (supply_mv_i < thr_mv[cmp_level_i]);
      end else begin
         // a stopped comparator means nothing, so never hold a plausible value
         cmp_below_o <= ~cmp_below_o;
      end
   end
endmodule

// ### tb/low_voltage_detect_control_test.sv
// low_voltage_detect_control_test: self-checking bench for lvdc_top.
// assumes lvdc_pkg and lvdc_top are compiled first; the filter is shortened.
`timescale 1ns/100ps
module low_voltage_detect_control_test;
   import lvdc_pkg::*;
   localparam int FILT = 8;
   localparam int LIMIT = 20000;
   localparam logic [15:0] HI = 16'h1388;
   localparam logic [15:0] LO = 16'h0A28;
   typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] r;} lvdc_row_t;
   lvdc_row_t rows [5] = '{'{LVDC_ADDR_LEVEL, 8'h0F, 8'h0F}, '{LVDC_ADDR_LEVEL, 8'h05, 8'h05},
      '{16'hFFC0, 8'h55, 8'h00}, '{LVDC_ADDR_CTRL, 8'h7E, 8'h02}, '{LVDC_ADDR_CTRL, 8'h00, 8'h00}};
   logic clk_i = 1'b0, sys_rst_i = 1'b1, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
   logic [15:0] bus_addr_i = 16'h0000, supply = HI;
   logic [7:0]  bus_wdata_i = 8'h00, bus_rdata_o;
   logic        dso = 1'b0, cmp_below, cmp_en, irq, rst, cause, mask;
   logic [3:0]  level;
   int          err_total = 0, tests_run = 0, cycles = 0, n;
   always #5 clk_i = ~clk_i;
   lvdc_top #(.FILT_CYCLES(FILT)) lvdc_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
      .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .default_start_option_i(dso),
      .cmp_below_i(cmp_below), .cmp_en_o(cmp_en), .cmp_level_o(level), .detect_irq_o(irq),
      .detect_reset_o(rst), .detect_reset_cause_set_o(cause), .detect_irq_mask_set_o(mask));
   lvdc_cmp_model lvdc_cmp_model_inst (.clk_i(clk_i), .cmp_en_i(cmp_en), .cmp_level_i(level),
      .supply_mv_i(supply), .cmp_below_o(cmp_below));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
   endtask
   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_i) #1;
      bus_addr_i = a;
      bus_wdata_i = v;
      bus_wr_i = 1'b1;
      @(posedge clk_i) #1;
      bus_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_i) #1;
      bus_addr_i = a;
      bus_rd_i = 1'b1;
      @(posedge clk_i) #1;
      bus_rd_i = 1'b0;
      chk8(bus_rdata_o, exp);
   endtask
   // sel 0 waits for an irq pulse, 1 for reset high, 2 for reset low
   task automatic wait_out(input int sel, input int max, output int cnt);
      cnt = max;
      for (int i = 0; i < max; i++) begin
         if ((sel == 0 ? irq : (sel == 1 ? rst : !rst)) === 1'b1) begin
            cnt = i;
            break;
         end
         @(posedge clk_i) #1;
      end
      if (cnt == max) fail("wait ran out");
   endtask
   task automatic irq_pulse(input int max, output int cnt);
      wait_out(0, max, cnt);
      @(posedge clk_i) #1;
      chk1(irq, 1'b0);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic sys_reset;
      @(posedge clk_i) #1;
      sys_rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      chk1(mask, 1'b1);
      #1 sys_rst_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail("run too long");
         results();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      sys_reset();
      chk1(mask, 1'b0);
      rd(LVDC_ADDR_CTRL, LVDC_CTRL_RESET);
      rd(LVDC_ADDR_LEVEL, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].r);
         if (rows[i].a == LVDC_ADDR_LEVEL) chk8({4'h0, level}, rows[i].r);
      end
      $display("test registers done");
      wr(LVDC_ADDR_CTRL, 8'h80);
      repeat (1100) @(posedge clk_i);
      chk1(cmp_en, 1'b1);
      rd(LVDC_ADDR_CTRL, 8'h80);
      supply = LO;
      irq_pulse(100, n);
      chk1(n >= FILT, 1'b1);
      rd(LVDC_ADDR_CTRL, 8'h81);
      chk1(rst, 1'b0);
      supply = HI;
      irq_pulse(100, n);
      rd(LVDC_ADDR_CTRL, 8'h80);
      supply = LO;
      irq_pulse(100, n);
      wr(LVDC_ADDR_CTRL, 8'h00);
      irq_pulse(5, n);
      rd(LVDC_ADDR_CTRL, 8'h00);
      $display("test interrupt mode done");
      supply = HI;
      wr(LVDC_ADDR_LEVEL, 8'h03);
      wr(LVDC_ADDR_CTRL, 8'h80);
      repeat (1100) @(posedge clk_i);
      rd(LVDC_ADDR_CTRL, 8'h80);
      wr(LVDC_ADDR_CTRL, 8'h82);
      supply = LO;
      wait_out(1, 100, n);
      chk1(cause, 1'b1);
      chk1(mask, 1'b1);
      rd(LVDC_ADDR_CTRL, 8'h83);
      rd(LVDC_ADDR_LEVEL, 8'h03);
      supply = HI;
      wait_out(2, 20, n);
      sys_reset();
      rd(LVDC_ADDR_CTRL, 8'h00);
      rd(LVDC_ADDR_LEVEL, 8'h00);
      $display("test reset mode done");
      dso = 1'b1;
      supply = LO;
      sys_reset();
      chk1(cmp_en, 1'b1);
      chk8({4'h0, level}, {4'h0, LVDC_DEFAULT_LEVEL});
      wait_out(1, 1200, n);
      supply = HI;
      wait_out(2, 20, n);
      wr(LVDC_ADDR_CTRL, 8'h00);
      dso = 1'b0;
      repeat (2) @(posedge clk_i);
      chk1(cmp_en, 1'b0);
      $display("test default start done");
      results();
   end
endmodule
